// >>> hdfsm_pkg.sv
/*
 Package for the halt dispatch state machine: register offsets, field
 positions, encodings of halt type, halt code, mailbox request and
 operator policy, state enumeration and the control word layout.
 Assumes nothing of its surroundings.
*/
package hdfsm_pkg;
   // Register byte offsets (APB, one word each)
   localparam logic [7:0] HDFSM_CTRL_OFS = 8'h00;
   localparam logic [7:0] HDFSM_COND_OFS = 8'h04;
   localparam logic [7:0] HDFSM_STAT_OFS = 8'h08;
   localparam logic [7:0] HDFSM_WORD_OFS = 8'h0c;
   // CTRL fields
   localparam int HDFSM_CTRL_ENTRY_BIT = 0;
   localparam int HDFSM_CTRL_PIO_ACK_BIT = 1;
   // COND fields
   localparam int HDFSM_COND_POLICY_LSB = 0;
   localparam int HDFSM_COND_ERR_BIT = 4;
   localparam int HDFSM_COND_TRACE_BIT = 5;
   localparam int HDFSM_COND_DIAG_BIT = 6;
   // Mailbox and diagnostic register bit positions
   localparam int HDFSM_MBX_REQ_LSB = 0;
   localparam int HDFSM_MBX_BOOT_BIT = 2;
   localparam int HDFSM_MBX_RST_BIT = 3;
   localparam int HDFSM_BDR_HEN_BIT = 7;
   // Restart reason position within the saved status word
   localparam int HDFSM_REASON_LSB = 8;
   localparam logic [5:0] HDFSM_REASON_EXT = 6'h02;
   localparam logic [5:0] HDFSM_REASON_PWR = 6'h03;
   localparam logic [5:0] HDFSM_REASON_HLT = 6'h06;
   // Halt codes
   localparam logic [1:0] HC_EXT = 2'h0;
   localparam logic [1:0] HC_PWR = 2'h1;
   localparam logic [1:0] HC_HLT = 2'h2;
   localparam logic [1:0] HC_ERR = 2'h3;
   // Halt types
   localparam logic [2:0] HT_PWRUP = 3'h0;
   localparam logic [2:0] HT_INPROG = 3'h1;
   localparam logic [2:0] HT_PWROK = 3'h2;
   localparam logic [2:0] HT_BREAK = 3'h3;
   localparam logic [2:0] HT_BUS_HALT_LINE = 3'h4;
   localparam logic [2:0] HT_RBOOT = 3'h5;
   // Mailbox requests
   localparam logic [1:0] MB_RBH = 2'h0;
   localparam logic [1:0] MB_RH = 2'h1;
   localparam logic [1:0] MB_BH = 2'h2;
   localparam logic [1:0] MB_H = 2'h3;
   // Operator policies
   localparam logic [2:0] UP_DEF = 3'h0;
   localparam logic [2:0] UP_RH = 3'h1;
   localparam logic [2:0] UP_BH = 3'h2;
   localparam logic [2:0] UP_H = 3'h3;
   localparam logic [2:0] UP_RBH = 3'h4;
   // Flag vector order: halt-enable, error, trace, diag, boot, restart
   localparam int HDFSM_CW_W = 16;
   typedef enum logic [3:0] {
      S_IDLE, S_ENTRY, S_RESET_INIT, S_BREAK_INIT, S_TRACE_INIT, S_OTHER_INIT,
      S_INIT, S_TRACE, S_BOOTSTRAP, S_RESTART, S_HALT, S_EXIT
   } hdfsm_state_t;
endpackage : hdfsm_pkg

// >>> hdfsm_dispatch.sv
/*
 Halt dispatch state machine with APB register access.
 Assumes a single 100 MHz clock, all inputs synchronous to it, and an
 APB master that keeps psel/penable/paddr/pwrite/pwdata stable.
*/
// Operation
// - Each halt entry starts at ENTRY, decides action
// - First matching row in order wins
// - Rebuild control word before every transition
// - Halt type encodings, valid with code 00
// - Restart reason compresses to 2-bit code
// - Operator policy encodings 000 through 100
// - Flags from diag bit 7, mailbox 2,3
// - ENTRY picks reset/break/trace/other initialization
// - Conditional inits go straight to INIT
// - External halts halt, except two boot cases
// - Halt instruction with trace goes TRACE
// - TRACE exits if trace, no error; else HALT
// - Power-up with all flags clear boots
// - Power-up, halts enabled, policy 010/100 boots
// - Non power-up, mailbox 10, clean flags boots
// - Mailbox 00, policy 010, clean flags boots
// - Failed restart with mailbox 00 boots
// - Three restart cases from INIT
// - Done states exit without error; exit to PIO
// - Catch-all rows go to HALT
`timescale 1ns/1ps
module hdfsm_dispatch
   import hdfsm_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_entry,
   input wire logic [2:0] halt_type,
   input wire logic [31:0] saved_status_word,
   input wire logic [31:0] console_mailbox,
   input wire logic [7:0] board_diag_register,
   output logic [3:0] dispatch_state,
   output logic do_bootstrap,
   output logic do_restart,
   output logic do_halt,
   output logic pio_mode
);
   typedef struct packed {
      hdfsm_state_t st;
      logic [2:0] policy;
      logic err;
      logic trace;
      logic diag;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic boot;
      logic rst;
      logic hlt;
      logic pio;
      logic [15:0] word;
   } hdfsm_regs_t;

   hdfsm_regs_t cur;
   hdfsm_regs_t nxt;

   // Compress the restart reason into the halt code
   function automatic logic [1:0] halt_code_of(input logic [5:0] reason);
      case (reason)
         HDFSM_REASON_EXT: halt_code_of = HC_EXT;
         HDFSM_REASON_PWR: halt_code_of = HC_PWR;
         HDFSM_REASON_HLT: halt_code_of = HC_HLT;
         default: halt_code_of = HC_ERR;
      endcase
   endfunction : halt_code_of

   // Control word fields, rebuilt live every cycle
   logic [1:0] hc;
   logic [1:0] mbx;
   logic [5:0] fl;
   logic f_hen;
   logic f_err;
   logic f_tip;
   logic [3:0] inner;
   assign hc = halt_code_of(saved_status_word[HDFSM_REASON_LSB +: 6]);
   assign mbx = console_mailbox[HDFSM_MBX_REQ_LSB +: 2];
   // Flags in order halt-enable, error, trace, diag, boot, restart
   assign fl = {board_diag_register[HDFSM_BDR_HEN_BIT], cur.err, cur.trace, cur.diag,
                console_mailbox[HDFSM_MBX_BOOT_BIT], console_mailbox[HDFSM_MBX_RST_BIT]};
   assign f_hen = fl[5];
   assign f_err = fl[4];
   assign f_tip = fl[3];
   assign inner = fl[3:0];

   // Next-state search: rows tested in table order, first match taken
   function automatic hdfsm_state_t next_of(input hdfsm_state_t s, input logic [2:0] ht,
         input logic [1:0] c, input logic [1:0] m, input logic [2:0] up,
         input logic halt_enable_flag, input logic er, input logic tp, input logic [3:0] in4);
      next_of = s;
      case (s)
         S_ENTRY: begin
            if (c == HC_PWR) next_of = S_RESET_INIT;
            else if (ht == HT_BREAK && c == HC_EXT) next_of = S_BREAK_INIT;
            else if (c == HC_HLT && !er && tp) next_of = S_TRACE_INIT;
            else next_of = S_OTHER_INIT;
         end
         S_RESET_INIT, S_BREAK_INIT, S_TRACE_INIT, S_OTHER_INIT: next_of = S_INIT;
         S_INIT: begin
            if (c == HC_EXT && ht == HT_PWROK && !halt_enable_flag) next_of = S_BOOTSTRAP;
            else if (c == HC_EXT && ht == HT_RBOOT) next_of = S_BOOTSTRAP;
            else if (c == HC_EXT) next_of = S_HALT;
            else if (c == HC_HLT && tp) next_of = S_TRACE;
            else if (c == HC_PWR && !halt_enable_flag && !er && !tp && in4 == 4'h0)
               next_of = S_BOOTSTRAP;
            else if (c == HC_PWR && halt_enable_flag && !er && in4 == 4'h0 && !tp
                     && (up == UP_BH || up == UP_RBH)) next_of = S_BOOTSTRAP;
            else if (c[1] && m == MB_BH && !er && !tp && in4 == 4'h0)
               next_of = S_BOOTSTRAP;
            else if (c[1] && m == MB_RBH && up == UP_BH && !er && !tp && in4 == 4'h0)
               next_of = S_BOOTSTRAP;
            else if (c[1] && m == MB_RBH && up == UP_RBH && !er && !tp && in4 == 4'h1)
               next_of = S_BOOTSTRAP;
            else if (c[1] && m == MB_RBH && up == UP_RBH && er && !tp && in4[3:1] == 3'h0)
               next_of = S_BOOTSTRAP;
            else if (c[1] && m == MB_RBH && up == UP_DEF && !halt_enable_flag && !er && !tp
                     && in4 == 4'h1) next_of = S_BOOTSTRAP;
            else if (c[1] && !er && !tp && in4 == 4'h0
                     && (m == MB_RH || (m == MB_RBH && (up == UP_RH || up == UP_RBH))
                         || (m == MB_RBH && up == UP_DEF && !halt_enable_flag)))
               next_of = S_RESTART;
            else next_of = S_HALT;
         end
         S_TRACE: begin
            if (c == HC_HLT && !er && tp) next_of = S_EXIT;
            else next_of = S_HALT;
         end
         S_RESTART: begin
            if (c[1] && m == MB_RBH && up == UP_DEF && !halt_enable_flag && er && !tp
                && in4[3:1] == 3'h0) next_of = S_BOOTSTRAP;
            else if (!er) next_of = S_EXIT;
            else next_of = S_HALT;
         end
         S_BOOTSTRAP, S_HALT: begin
            if (!er) next_of = S_EXIT;
            else next_of = S_HALT;
         end
         S_EXIT: next_of = S_IDLE;
         S_IDLE: next_of = S_IDLE;
         default: next_of = S_IDLE;
      endcase
   endfunction : next_of

   // Next-value logic: APB slave, halt entry, state walk
   always_comb begin
      logic wr;
      logic rd_cyc;
      logic entry;
      logic pio_ack;
      hdfsm_state_t ns;
      nxt = cur;
      wr = 1'b0;
      rd_cyc = 1'b0;
      entry = halt_entry;
      pio_ack = 1'b0;
      ns = cur.st;
      nxt.ready = 1'b0;
      nxt.slverr = 1'b0;
      nxt.rdata = 32'h0000_0000;
      // APB access answered one cycle after the access phase opens
      if (psel && penable && !cur.ready) begin
         nxt.ready = 1'b1;
         wr = pwrite;
         rd_cyc = !pwrite;
         case (paddr)
            HDFSM_CTRL_OFS: begin
               if (wr) begin
                  entry = entry | pwdata[HDFSM_CTRL_ENTRY_BIT];
                  pio_ack = pwdata[HDFSM_CTRL_PIO_ACK_BIT];
               end
               if (rd_cyc) nxt.rdata = {31'h0, cur.pio};
            end
            HDFSM_COND_OFS: begin
               if (wr) begin
                  nxt.policy = pwdata[HDFSM_COND_POLICY_LSB +: 3];
                  nxt.err = pwdata[HDFSM_COND_ERR_BIT];
                  nxt.trace = pwdata[HDFSM_COND_TRACE_BIT];
                  nxt.diag = pwdata[HDFSM_COND_DIAG_BIT];
               end
               if (rd_cyc) nxt.rdata = {25'h0, cur.diag, cur.trace, cur.err, 1'b0, cur.policy};
            end
            HDFSM_STAT_OFS: begin
               if (rd_cyc) nxt.rdata = {24'h0, cur.pio, cur.hlt, cur.rst, cur.boot,
                                        4'(cur.st)};
               nxt.slverr = wr;
            end
            HDFSM_WORD_OFS: begin
               if (rd_cyc) nxt.rdata = {16'h0, cur.word};
               nxt.slverr = wr;
            end
            default: nxt.slverr = 1'b1;
         endcase
      end
      // Live control word, exposed for software; fields fill all 16 bits
      nxt.word = {halt_type, hc, mbx, cur.policy, fl};
      if (pio_ack) nxt.pio = 1'b0;
      if (entry) begin
         nxt.st = S_ENTRY;
         nxt.boot = 1'b0;
         nxt.rst = 1'b0;
         nxt.hlt = 1'b0;
         nxt.pio = 1'b0;
      end else begin
         ns = next_of(cur.st, halt_type, hc, mbx, cur.policy, f_hen, f_err, f_tip, inner);
         nxt.st = ns;
         if (ns == S_BOOTSTRAP && cur.st != S_BOOTSTRAP) nxt.boot = 1'b1;
         if (ns == S_RESTART && cur.st != S_RESTART) nxt.rst = 1'b1;
         if (ns == S_HALT && cur.st != S_HALT) nxt.hlt = 1'b1;
         if (cur.st == S_EXIT) nxt.pio = 1'b1;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '{st: S_IDLE, policy: UP_DEF, default: '0};
      end else begin
         cur <= nxt;
      end
   end

   // Outputs straight from flops
   assign prdata = cur.rdata;
   assign pready = cur.ready;
   assign pslverr = cur.slverr;
   assign dispatch_state = 4'(cur.st);
   assign do_bootstrap = cur.boot;
   assign do_restart = cur.rst;
   assign do_halt = cur.hlt;
   assign pio_mode = cur.pio;

   // Checks
   property p_entry_start;
      @(posedge core_clk) disable iff (!arst_n) halt_entry |=> cur.st == S_ENTRY;
   endproperty
   a_entry_start: assert property (p_entry_start) else $error("entry not taken");
   property p_init_join;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st inside {S_RESET_INIT, S_BREAK_INIT, S_TRACE_INIT, S_OTHER_INIT})
         |=> cur.st == S_INIT;
   endproperty
   a_init_join: assert property (p_init_join) else $error("init join missed");
   property p_reset_init;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_ENTRY && hc == HC_PWR) |=> cur.st == S_RESET_INIT;
   endproperty
   a_reset_init: assert property (p_reset_init) else $error("reset init missed");
   property p_ext_halt;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc == HC_EXT && halt_type == HT_BUS_HALT_LINE)
         |=> cur.st == S_HALT;
   endproperty
   a_ext_halt: assert property (p_ext_halt) else $error("external halt wrong");
   property p_trace;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc == HC_HLT && f_tip) |=> cur.st == S_TRACE;
   endproperty
   a_trace: assert property (p_trace) else $error("trace entry missed");
   property p_trace_out;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_TRACE && f_err) |=> cur.st == S_HALT;
   endproperty
   a_trace_out: assert property (p_trace_out) else $error("trace exit wrong");
   // Two-step walks; a new halt entry in the middle cuts them short legally
   sequence s_exit_then_pio;
      cur.st == S_EXIT ##1 (pio_mode || cur.st == S_ENTRY);
   endsequence
   sequence s_boot_then_flag;
      cur.st == S_BOOTSTRAP ##1 (do_bootstrap || cur.st == S_ENTRY);
   endsequence
   property p_exit;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_HALT && !f_err) |=> s_exit_then_pio;
   endproperty
   a_exit: assert property (p_exit) else $error("exit path wrong");
   property p_pwr_boot;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc == HC_PWR && fl == 6'h00)
         |=> s_boot_then_flag;
   endproperty
   a_pwr_boot: assert property (p_pwr_boot) else $error("power-up boot missed");
   property p_apb;
      @(posedge core_clk) disable iff (!arst_n) (psel && penable && !pready) |=> pready;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");
   // Further table rows, one property per row group
   property p_break_init;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_ENTRY && hc == HC_EXT && halt_type == HT_BREAK)
         |=> cur.st == S_BREAK_INIT;
   endproperty
   a_break_init: assert property (p_break_init) else $error("break init missed");
   property p_trace_init;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_ENTRY && hc == HC_HLT && !f_err && f_tip)
         |=> cur.st == S_TRACE_INIT;
   endproperty
   a_trace_init: assert property (p_trace_init) else $error("trace init missed");
   property p_other_init;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_ENTRY && hc == HC_ERR)
         |=> cur.st == S_OTHER_INIT;
   endproperty
   a_other_init: assert property (p_other_init) else $error("other init missed");
   property p_ext_boot;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc == HC_EXT
          && (halt_type == HT_RBOOT || (halt_type == HT_PWROK && !f_hen)))
         |=> cur.st == S_BOOTSTRAP;
   endproperty
   a_ext_boot: assert property (p_ext_boot) else $error("external boot missed");
   property p_trace_exit;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_TRACE && hc == HC_HLT && !f_err && f_tip)
         |=> cur.st == S_EXIT;
   endproperty
   a_trace_exit: assert property (p_trace_exit) else $error("trace exit missed");
   property p_pwr_boot_en;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc == HC_PWR && fl == 6'h20
          && (cur.policy == UP_BH || cur.policy == UP_RBH)) |=> cur.st == S_BOOTSTRAP;
   endproperty
   a_pwr_boot_en: assert property (p_pwr_boot_en) else $error("enabled boot missed");
   property p_mbx_boot;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc[1] && mbx == MB_BH && fl[4:0] == 5'h00)
         |=> cur.st == S_BOOTSTRAP;
   endproperty
   a_mbx_boot: assert property (p_mbx_boot) else $error("mailbox boot missed");
   property p_policy_boot;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc[1] && mbx == MB_RBH && cur.policy == UP_BH
          && fl[4:0] == 5'h00) |=> cur.st == S_BOOTSTRAP;
   endproperty
   a_policy_boot: assert property (p_policy_boot) else $error("policy boot missed");
   property p_fail_boot;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc[1] && mbx == MB_RBH && cur.policy == UP_RBH
          && fl[4:0] == 5'h01) |=> cur.st == S_BOOTSTRAP;
   endproperty
   a_fail_boot: assert property (p_fail_boot) else $error("failed restart boot");
   property p_mbx_restart;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st == S_INIT && hc[1] && mbx == MB_RH && fl[4:0] == 5'h00)
         |=> cur.st == S_RESTART;
   endproperty
   a_mbx_restart: assert property (p_mbx_restart) else $error("restart missed");
   property p_done_exit;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st inside {S_BOOTSTRAP, S_RESTART} && !f_err)
         |=> cur.st == S_EXIT;
   endproperty
   a_done_exit: assert property (p_done_exit) else $error("done exit missed");
   property p_err_halt;
      @(posedge core_clk) disable iff (!arst_n)
         (!halt_entry && cur.st inside {S_BOOTSTRAP, S_HALT} && f_err)
         |=> cur.st == S_HALT;
   endproperty
   a_err_halt: assert property (p_err_halt) else $error("error halt missed");
   property p_entry_clear;
      @(posedge core_clk) disable iff (!arst_n)
         halt_entry |=> !(do_bootstrap || do_restart || do_halt || pio_mode);
   endproperty
   a_entry_clear: assert property (p_entry_clear) else $error("entry left flags");
endmodule : hdfsm_dispatch

// >>> hdfsm_halt_src.sv
/*
 Model of the processor halt entry logic and external halt sources.
 Assumes the bench pulses fire for one cycle; the fields then stay live
 until the next fire, as the machine condition of the halted processor.
*/
`timescale 1ns/1ps
module hdfsm_halt_src
   import hdfsm_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic fire,
   input wire logic [2:0] f_type,
   input wire logic [5:0] f_reason,
   input wire logic [3:0] f_mbx,
   input wire logic f_hen,
   output logic halt_entry,
   output logic [2:0] halt_type,
   output logic [31:0] saved_status_word,
   output logic [31:0] console_mailbox,
   output logic [7:0] board_diag_register
);
   // One-cycle entry strobe, fields held live; unused bits carry junk
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         halt_entry <= 1'b0;
         halt_type <= 3'h0;
         saved_status_word <= 32'h0;
         console_mailbox <= 32'h0;
         board_diag_register <= 8'h0;
      end else begin
         halt_entry <= fire;
         if (fire) begin
            halt_type <= f_type;
            saved_status_word <= {16'ha5c3, 2'h2, f_reason, 8'h5a};
            console_mailbox <= {28'h3c96e1d, f_mbx};
            board_diag_register <= {f_hen, 7'h55};
         end
      end
   end
endmodule : hdfsm_halt_src

// >>> halt_dispatch_fsm_tb_top.sv
/*
 Self-checking testbench for the halt dispatch state machine.
 Assumes APB answers one wait state after the access phase and that
 each state transition takes one clock.
*/
`timescale 1ns/1ps
module halt_dispatch_fsm_tb_top
   import hdfsm_pkg::*;
;
   logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, board_diag_register;
   logic [31:0] pwdata, prdata, rd, saved_status_word, console_mailbox;
   logic fire, f_hen, halt_entry, do_bootstrap, do_restart, do_halt, pio_mode;
   logic [2:0] f_type, halt_type;
   logic [5:0] f_reason;
   logic [3:0] f_mbx, dispatch_state;
   logic [2:0] tl [3];
   int errors = 0, tests_run = 0, cycles = 0, ncase = 0;

   hdfsm_dispatch u_hdfsm_dispatch (.core_clk, .arst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_entry, .halt_type,
      .saved_status_word, .console_mailbox, .board_diag_register, .dispatch_state,
      .do_bootstrap, .do_restart, .do_halt, .pio_mode);
   hdfsm_halt_src u_hdfsm_halt_src (.core_clk, .arst_n, .fire, .f_type, .f_reason,
      .f_mbx, .f_hen, .halt_entry, .halt_type, .saved_status_word, .console_mailbox,
      .board_diag_register);

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         errors++;
         test_done();
      end
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   task automatic cmp_state(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected state at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_state

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   // One APB transfer; read data and error land in rd and er
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Ends when pready rises; only the hang guard bounds this wait
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Sets the software flags, fires one halt and follows the walk
   task automatic run_case(input logic [2:0] ty, input logic [5:0] rs, input logic [3:0] mb,
      input logic halt_enable_flag, input logic [7:0] cond, input hdfsm_state_t xi,
      input hdfsm_state_t act, input hdfsm_state_t fin);
      logic [3:0] seq [6];
      hdfsm_state_t idle;
      logic h;
      apb(HDFSM_COND_OFS, 1'b1, {24'h0, cond});
      @(posedge core_clk);
      fire <= 1'b1;
      f_type <= ty;
      f_reason <= rs;
      f_mbx <= mb;
      f_hen <= halt_enable_flag;
      @(posedge core_clk);
      fire <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk);
         #1 seq[i] = dispatch_state;
      end
      idle = (fin == S_EXIT) ? S_IDLE : S_HALT;
      h = (act == S_HALT) || (fin == S_HALT);
      cmp_state(seq[0], S_ENTRY);
      cmp_state(seq[1], xi);
      cmp_state(seq[2], S_INIT);
      cmp_state(seq[3], act);
      cmp_state(seq[4], fin);
      cmp_state(seq[5], idle);
      cmp_word({28'h0, pio_mode, do_halt, do_restart, do_bootstrap},
         {28'h0, fin == S_EXIT, h, act == S_RESTART, act == S_BOOTSTRAP});
      apb(HDFSM_STAT_OFS, 1'b0, 32'h0);
      cmp_word(rd, {24'h0, fin == S_EXIT, h, act == S_RESTART, act == S_BOOTSTRAP,
         4'(idle)});
      ncase++;
      $display("case %0d done", ncase);
   endtask : run_case

   // Main sequence
   initial begin
      {arst_n, psel, penable, pwrite, fire, f_hen} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      {f_type, f_reason, f_mbx} = 13'h0;
      tl = '{3'h0, 3'h1, 3'h4};
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      #1 cmp_state(dispatch_state, S_IDLE);
      cmp_word({28'h0, pio_mode, do_halt, do_restart, do_bootstrap}, 32'h0);
      apb(HDFSM_COND_OFS, 1'b0, 32'h0);
      cmp_word(rd, 32'h0);
      apb(HDFSM_COND_OFS, 1'b1, 32'h73);
      apb(HDFSM_COND_OFS, 1'b0, 32'h0);
      cmp_word(rd, 32'h73);
      apb(8'h10, 1'b0, 32'h0);
      cmp_word({31'h0, er}, 32'h1);
      apb(HDFSM_STAT_OFS, 1'b1, 32'hff);
      cmp_word({31'h0, er}, 32'h1);
      $display("register checks done");
      run_case(3'h3, 6'h02, 4'h0, 1'b1, 8'h00, S_BREAK_INIT, S_HALT, S_EXIT);
      run_case(3'h2, 6'h02, 4'h0, 1'b0, 8'h00, S_OTHER_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h2, 6'h02, 4'h0, 1'b1, 8'h00, S_OTHER_INIT, S_HALT, S_EXIT);
      run_case(3'h5, 6'h02, 4'h0, 1'b1, 8'h00, S_OTHER_INIT, S_BOOTSTRAP, S_EXIT);
      foreach (tl[i]) run_case(tl[i], 6'h02, 4'h0, 1'b0, 8'h00, S_OTHER_INIT, S_HALT,
         S_EXIT);
      run_case(3'h5, 6'h03, 4'h0, 1'b0, 8'h00, S_RESET_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h5, 6'h03, 4'h0, 1'b1, 8'h02, S_RESET_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h0, 6'h03, 4'h0, 1'b1, 8'h04, S_RESET_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h5, 6'h03, 4'h0, 1'b1, 8'h03, S_RESET_INIT, S_HALT, S_EXIT);
      run_case(3'h0, 6'h03, 4'h4, 1'b0, 8'h00, S_RESET_INIT, S_HALT, S_EXIT);
      run_case(3'h0, 6'h06, 4'h0, 1'b1, 8'h20, S_TRACE_INIT, S_TRACE, S_EXIT);
      run_case(3'h0, 6'h06, 4'h0, 1'b1, 8'h30, S_OTHER_INIT, S_TRACE, S_HALT);
      run_case(3'h0, 6'h07, 4'h2, 1'b1, 8'h03, S_OTHER_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h0, 6'h06, 4'h0, 1'b1, 8'h02, S_OTHER_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h0, 6'h3f, 4'h8, 1'b1, 8'h04, S_OTHER_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h0, 6'h07, 4'h0, 1'b1, 8'h14, S_OTHER_INIT, S_BOOTSTRAP, S_HALT);
      run_case(3'h0, 6'h07, 4'h8, 1'b0, 8'h00, S_OTHER_INIT, S_BOOTSTRAP, S_EXIT);
      run_case(3'h0, 6'h07, 4'h1, 1'b1, 8'h03, S_OTHER_INIT, S_RESTART, S_EXIT);
      run_case(3'h0, 6'h06, 4'h0, 1'b1, 8'h01, S_OTHER_INIT, S_RESTART, S_EXIT);
      run_case(3'h0, 6'h07, 4'h0, 1'b1, 8'h04, S_OTHER_INIT, S_RESTART, S_EXIT);
      run_case(3'h0, 6'h07, 4'h0, 1'b0, 8'h00, S_OTHER_INIT, S_RESTART, S_EXIT);
      run_case(3'h0, 6'h07, 4'h0, 1'b1, 8'h00, S_OTHER_INIT, S_HALT, S_EXIT);
      run_case(3'h0, 6'h07, 4'h3, 1'b1, 8'h00, S_OTHER_INIT, S_HALT, S_EXIT);
      run_case(3'h0, 6'h07, 4'h2, 1'b1, 8'h40, S_OTHER_INIT, S_HALT, S_EXIT);
      run_case(3'h4, 6'h02, 4'h0, 1'b1, 8'h10, S_OTHER_INIT, S_HALT, S_HALT);
      run_case(3'h0, 6'h00, 4'h2, 1'b1, 8'h00, S_OTHER_INIT, S_BOOTSTRAP, S_EXIT);
      // Software leaves program I/O mode
      apb(HDFSM_CTRL_OFS, 1'b1, 32'h2);
      apb(HDFSM_CTRL_OFS, 1'b0, 32'h0);
      cmp_word({31'h0, rd[0]}, 32'h0);
      cmp_word({31'h0, pio_mode}, 32'h0);
      // Control word still tracks the last halt's live fields
      apb(HDFSM_WORD_OFS, 1'b0, 32'h0);
      cmp_word(rd, {16'h0, HT_PWRUP, HC_ERR, MB_BH, UP_DEF, 6'h20});
      $display("program I/O clear and word done");
      test_done();
   end
endmodule : halt_dispatch_fsm_tb_top
